// [logic/spcch_params.svh]
// Purpose: Constants for the switch port command header block
// Assumes: Dword-addressed configuration accesses, byte offsets kept as printed
// Notes: Identification defaults below are arbitrary neutral values
`ifndef SPCCH_PARAMS_SVH
`define SPCCH_PARAMS_SVH

`define SPCCH_OFS_IDENT 12'h000
`define SPCCH_OFS_CMD 12'h004

`define SPCCH_MAKER_LSB 0
`define SPCCH_PART_LSB 16

// Arbitrary identification defaults, not tied to any maker or part
`define SPCCH_MAKER_RST 16'h0A5A
`define SPCCH_PART_RST 16'h0001

`define SPCCH_CMD_IO_EN 0
`define SPCCH_CMD_MEM_EN 1
`define SPCCH_CMD_UP_FWD 2
`define SPCCH_CMD_PAR_RSP 6
`define SPCCH_CMD_ERR_RPT 8
`define SPCCH_CMD_INTX_DIS 10

`define SPCCH_CMD_RST 16'h0000
`define SPCCH_CMD_WMASK 16'h0547

`endif

// [logic/spcch_pkg.sv]
// Purpose: Types shared by the switch port command header block
// Assumes: spcch_params.svh holds all numeric constants
// Notes: Structs carry grouped request signals
`default_nettype none
package spcch_pkg;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] offset;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } spcch_cfg_req_type;

    typedef struct packed {
        logic valid;
        logic [1:0] half_en;
        logic [31:0] data;
    } spcch_id_load_type;

    typedef struct packed {
        logic valid;
        logic is_io;
        logic is_mem;
    } spcch_pri_req_type;

    typedef struct packed {
        logic valid;
        logic is_io;
        logic is_mem;
        logic non_posted;
        logic is_intx;
    } spcch_dn_req_type;

    typedef enum logic [1:0] {
        SPCCH_DN_NONE,
        SPCCH_DN_FORWARD,
        SPCCH_DN_UR_DROP,
        SPCCH_DN_UR_CPL
    } spcch_dn_verdict_type;

endpackage
`default_nettype wire

// [logic/spcch_top.sv]
// Purpose: Identification words and command register of a switch port header
// Assumes: Configuration requests and traffic classification arrive decoded
// Notes: All answers and verdicts are registered, one cycle after the request
//        Byte lanes 2 and 3 of a command write carry nothing and are ignored
`include "spcch_params.svh"
`default_nettype none

// Operation
// - Dword 0 bits 15:0 hold read-only maker identification, reloadable by side load.
// - Dword 0 bits 31:16 hold read-only part identification, reloadable by side load.
// - Command bit 0 resets 0; port answers I/O requests only when set.
// - Command bit 1 resets 0; port answers memory requests only when set.
// - Command bit 2 clear blocks upstream memory and I/O, marking them Unsupported.
// - Rejected non-posted requests under cleared bit 2 get an Unsupported completion.
// - Command bit 2 set forwards downstream memory and I/O requests upstream.
// - Command bits 3, 4, 5, 7, 9 read zero and ignore writes.
// - Command bit 6 resets 0; parity errors acted upon only when set.
// - Command bit 8 resets 0; gates fatal and non-fatal error reporting.
// - Command bit 10 set suppresses this port's own INTx messages.
// - Downstream INTx messages are relayed regardless of command bit 10.
module spcch_top (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Configuration access from the upstream link
    input wire spcch_pkg::spcch_cfg_req_type cfg_req_i,
    output logic cfg_ack_o,
    output logic [31:0] cfg_rdata_o,
    // Identification load from SMBus or EEPROM
    input wire spcch_pkg::spcch_id_load_type id_load_i,
    // Requests on the primary side aimed at this port
    input wire spcch_pkg::spcch_pri_req_type pri_req_i,
    output logic pri_claim_o,
    output logic pri_ignore_o,
    // Requests from the downstream side heading upstream
    input wire spcch_pkg::spcch_dn_req_type dn_req_i,
    output spcch_pkg::spcch_dn_verdict_type dn_verdict_o,
    // Events raised inside the port
    input wire logic parity_err_i,
    input wire logic err_nonfatal_i,
    input wire logic err_fatal_i,
    input wire logic own_intx_i,
    output logic parity_act_o,
    output logic err_nonfatal_msg_o,
    output logic err_fatal_msg_o,
    output logic own_intx_msg_o,
    // Command register state
    output logic [15:0] cmd_o
);
    import spcch_pkg::*;

    localparam logic [15:0] CMD_RST_WORD = `SPCCH_CMD_RST;

    // Identification
    logic [15:0] maker_id_ff;
    logic [15:0] part_id_ff;

    // Command fields, one flop for each implemented bit
    logic cmd_io_en_ff;
    logic cmd_mem_en_ff;
    logic cmd_up_fwd_ff;
    logic cmd_par_rsp_ff;
    logic cmd_err_rpt_ff;
    logic cmd_intx_dis_ff;
    logic [15:0] cmd_word;

    // Configuration answer
    logic cfg_ack_ff;
    logic [31:0] cfg_rdata_ff;
    logic [31:0] nxt_rdata;

    // Traffic answers
    logic pri_claim_ff;
    logic pri_ignore_ff;
    spcch_dn_verdict_type dn_verdict_ff;
    spcch_dn_verdict_type nxt_verdict;

    // Event answers
    logic parity_act_ff;
    logic err_nf_ff;
    logic err_f_ff;
    logic own_intx_ff;

    // Request decode
    logic hit_cmd_wr;
    logic wr_cmd_lo;
    logic wr_cmd_hi;
    logic pri_io_hit;
    logic pri_mem_hit;

    assign hit_cmd_wr = cfg_req_i.valid && cfg_req_i.write && (cfg_req_i.offset == `SPCCH_OFS_CMD);
    // Lane 0 carries command bits 7:0, lane 1 bits 15:8
    assign wr_cmd_lo = hit_cmd_wr && cfg_req_i.byte_en[0];
    assign wr_cmd_hi = hit_cmd_wr && cfg_req_i.byte_en[1];
    // Requests with neither class bit set are neither claimed nor ignored
    assign pri_io_hit = pri_req_i.valid && pri_req_i.is_io;
    assign pri_mem_hit = pri_req_i.valid && pri_req_i.is_mem;

    // Identification words: configuration writes never reach them, only the side load does
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            maker_id_ff <= `SPCCH_MAKER_RST;
        end else if (id_load_i.valid && id_load_i.half_en[0]) begin
            maker_id_ff <= id_load_i.data[`SPCCH_MAKER_LSB +: 16];
        end
    end

    // The halves load independently, so a side load may replace just one of them
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            part_id_ff <= `SPCCH_PART_RST;
        end else if (id_load_i.valid && id_load_i.half_en[1]) begin
            part_id_ff <= id_load_i.data[`SPCCH_PART_LSB +: 16];
        end
    end

    // Each implemented bit is its own flop, written only through the lane that holds it
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_io_en_ff <= CMD_RST_WORD[`SPCCH_CMD_IO_EN];
        end else if (wr_cmd_lo) begin
            cmd_io_en_ff <= cfg_req_i.wdata[`SPCCH_CMD_IO_EN];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_mem_en_ff <= CMD_RST_WORD[`SPCCH_CMD_MEM_EN];
        end else if (wr_cmd_lo) begin
            cmd_mem_en_ff <= cfg_req_i.wdata[`SPCCH_CMD_MEM_EN];
        end
    end

    // Clearing bit 2 turns away upstream memory and I/O requests from the very next request on
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_up_fwd_ff <= CMD_RST_WORD[`SPCCH_CMD_UP_FWD];
        end else if (wr_cmd_lo) begin
            cmd_up_fwd_ff <= cfg_req_i.wdata[`SPCCH_CMD_UP_FWD];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_par_rsp_ff <= CMD_RST_WORD[`SPCCH_CMD_PAR_RSP];
        end else if (wr_cmd_lo) begin
            cmd_par_rsp_ff <= cfg_req_i.wdata[`SPCCH_CMD_PAR_RSP];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_err_rpt_ff <= CMD_RST_WORD[`SPCCH_CMD_ERR_RPT];
        end else if (wr_cmd_hi) begin
            cmd_err_rpt_ff <= cfg_req_i.wdata[`SPCCH_CMD_ERR_RPT];
        end
    end

    // Interrupt disable masks only this port's own messages, never relayed ones
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_intx_dis_ff <= CMD_RST_WORD[`SPCCH_CMD_INTX_DIS];
        end else if (wr_cmd_hi) begin
            cmd_intx_dis_ff <= cfg_req_i.wdata[`SPCCH_CMD_INTX_DIS];
        end
    end

    // Fixed and reserved positions are constant zero, so writes to them have nowhere to land
    always_comb begin
        cmd_word = 16'h0000;
        cmd_word[`SPCCH_CMD_IO_EN] = cmd_io_en_ff;
        cmd_word[`SPCCH_CMD_MEM_EN] = cmd_mem_en_ff;
        cmd_word[`SPCCH_CMD_UP_FWD] = cmd_up_fwd_ff;
        cmd_word[`SPCCH_CMD_PAR_RSP] = cmd_par_rsp_ff;
        cmd_word[`SPCCH_CMD_ERR_RPT] = cmd_err_rpt_ff;
        cmd_word[`SPCCH_CMD_INTX_DIS] = cmd_intx_dis_ff;
    end

    // Read data; unmapped offsets answer zero so probing software sees nothing
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (cfg_req_i.offset == `SPCCH_OFS_IDENT) begin
            nxt_rdata = {part_id_ff, maker_id_ff};
        end else if (cfg_req_i.offset == `SPCCH_OFS_CMD) begin
            nxt_rdata = {16'h0000, cmd_word};
        end
    end

    // Every request is acknowledged, including writes that land nowhere
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_ack_ff <= 1'b0;
        end else begin
            cfg_ack_ff <= cfg_req_i.valid;
        end
    end

    // Writes leave the last read word standing
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_rdata_ff <= 32'h0000_0000;
        end else if (cfg_req_i.valid && !cfg_req_i.write) begin
            cfg_rdata_ff <= nxt_rdata;
        end
    end

    // Primary side decoding of I/O and memory requests
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pri_claim_ff <= 1'b0;
        end else begin
            pri_claim_ff <= (pri_io_hit && cmd_io_en_ff)
                || (pri_mem_hit && cmd_mem_en_ff);
        end
    end

    // An ignored request is flagged so the primary side can drop it without an answer
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pri_ignore_ff <= 1'b0;
        end else begin
            pri_ignore_ff <= (pri_io_hit && !cmd_io_en_ff)
                || (pri_mem_hit && !cmd_mem_en_ff);
        end
    end

    // Upstream forwarding verdict for downstream traffic
    always_comb begin
        nxt_verdict = SPCCH_DN_NONE;
        if (dn_req_i.valid) begin
            if (dn_req_i.is_intx) begin
                nxt_verdict = SPCCH_DN_FORWARD;
            end else if (dn_req_i.is_io || dn_req_i.is_mem) begin
                if (cmd_up_fwd_ff) begin
                    nxt_verdict = SPCCH_DN_FORWARD;
                end else if (dn_req_i.non_posted) begin
                    nxt_verdict = SPCCH_DN_UR_CPL;
                end else begin
                    // Posted requests earn no completion, so a refused one is simply dropped
                    nxt_verdict = SPCCH_DN_UR_DROP;
                end
            end
        end
    end

    // The verdict stands one cycle only; the forwarding logic must act on it at once
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dn_verdict_ff <= SPCCH_DN_NONE;
        end else begin
            dn_verdict_ff <= nxt_verdict;
        end
    end

    // Events are one-cycle pulses; one that arrives while its gate is shut is dropped, not held
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            parity_act_ff <= 1'b0;
        end else begin
            parity_act_ff <= parity_err_i && cmd_par_rsp_ff;
        end
    end

    // Both error classes share the one reporting enable
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_nf_ff <= 1'b0;
        end else begin
            err_nf_ff <= err_nonfatal_i && cmd_err_rpt_ff;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_f_ff <= 1'b0;
        end else begin
            err_f_ff <= err_fatal_i && cmd_err_rpt_ff;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            own_intx_ff <= 1'b0;
        end else begin
            own_intx_ff <= own_intx_i && !cmd_intx_dis_ff;
        end
    end

    assign cfg_ack_o = cfg_ack_ff;
    assign cfg_rdata_o = cfg_rdata_ff;
    assign pri_claim_o = pri_claim_ff;
    assign pri_ignore_o = pri_ignore_ff;
    assign dn_verdict_o = dn_verdict_ff;
    assign parity_act_o = parity_act_ff;
    assign err_nonfatal_msg_o = err_nf_ff;
    assign err_fatal_msg_o = err_f_ff;
    assign own_intx_msg_o = own_intx_ff;
    assign cmd_o = cmd_word;

endmodule
`default_nettype wire

// [bench/spcch_props.sv]
// Purpose: Port-level checks of the command header block
// Assumes: One clock domain, bound into spcch_top
// Notes: Register contents are left to the bench
`include "spcch_params.svh"
`default_nettype none
module spcch_props (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Requests
    input wire spcch_pkg::spcch_cfg_req_type cfg_req_i,
    input wire spcch_pkg::spcch_pri_req_type pri_req_i,
    input wire spcch_pkg::spcch_dn_req_type dn_req_i,
    input wire logic parity_err_i,
    input wire logic err_fatal_i,
    input wire logic own_intx_i,
    // Answers
    input wire logic cfg_ack_o,
    input wire logic pri_claim_o,
    input wire logic pri_ignore_o,
    input wire spcch_pkg::spcch_dn_verdict_type dn_verdict_o,
    input wire logic parity_act_o,
    input wire logic err_fatal_msg_o,
    input wire logic own_intx_msg_o,
    input wire logic [15:0] cmd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import spcch_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    logic io_mem;
    assign io_mem = dn_req_i.valid && (dn_req_i.is_io || dn_req_i.is_mem) && !dn_req_i.is_intx;
    cfg_ack_a: assert property (cfg_req_i.valid |=> cfg_ack_o) else $error("no ack");
    cmd_fixed_a: assert property ((cmd_o & ~`SPCCH_CMD_WMASK) == 16'h0000)
        else $error("fixed bit set");
    io_claim_a: assert property (pri_req_i.valid && pri_req_i.is_io && !pri_req_i.is_mem |=>
        pri_claim_o == $past(cmd_o[0])) else $error("io claim wrong");
    mem_ignore_a: assert property (pri_req_i.valid && pri_req_i.is_mem && !pri_req_i.is_io |=>
        pri_ignore_o != $past(cmd_o[1])) else $error("mem ignore wrong");
    up_fwd_a: assert property (io_mem && cmd_o[2] |=> dn_verdict_o == SPCCH_DN_FORWARD)
        else $error("no forward");
    ur_reply_a: assert property (io_mem && !cmd_o[2] |=>
        dn_verdict_o[1] && dn_verdict_o[0] == $past(dn_req_i.non_posted)) else $error("bad UR verdict");
    intx_relay_a: assert property (dn_req_i.valid && dn_req_i.is_intx |=> dn_verdict_o == SPCCH_DN_FORWARD)
        else $error("intx not relayed");
    parity_gate_a: assert property (parity_act_o == ($past(parity_err_i) && $past(cmd_o[6])))
        else $error("parity gate wrong");
    err_gate_a: assert property (err_fatal_i |=> err_fatal_msg_o == $past(cmd_o[8])) else $error("err gate");
    own_intx_a: assert property (own_intx_i |=> own_intx_msg_o != $past(cmd_o[10])) else $error("intx gate");
endmodule
bind spcch_top spcch_props chk_u (.*);
`default_nettype wire

// [bench/spcch_rc_model.sv]
// Purpose: Upstream requester that delivers configuration requests
// Assumes: The bench hands each request over for one cycle
// Notes: One link cycle of delay, as a real requester would add
`default_nettype none
module spcch_rc_model (
    // Clock
    input wire logic ref_clk_i,
    // Request from the bench and toward the block
    input wire spcch_pkg::spcch_cfg_req_type tlp_i,
    output spcch_pkg::spcch_cfg_req_type cfg_req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import spcch_pkg::*;
    always_ff @(posedge ref_clk_i) begin
        cfg_req_o <= tlp_i;
    end
endmodule
`default_nettype wire

// [bench/spcch_top_test.sv]
// Purpose: Self-checking bench for the command header block
// Assumes: Configuration requests reach the block through the requester model; traffic inputs are driven directly
// Notes: Traffic checks loop over several command values
`include "spcch_params.svh"
`default_nettype none
module spcch_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import spcch_pkg::*;
    logic ref_clk_i = 0;
    logic resetn_i = 0;
    spcch_cfg_req_type tlp = '0;
    spcch_cfg_req_type cfg_req_i;
    spcch_id_load_type id_load_i = '0;
    spcch_pri_req_type pri_req_i = '0;
    spcch_dn_req_type dn_req_i = '0;
    logic parity_err_i = 0, err_nonfatal_i = 0, err_fatal_i = 0, own_intx_i = 0;
    logic cfg_ack_o, pri_claim_o, pri_ignore_o, parity_act_o, err_nonfatal_msg_o, err_fatal_msg_o, own_intx_msg_o;
    logic [31:0] cfg_rdata_o, r;
    logic [15:0] cmd_o;
    logic [15:0] vals [3] = '{16'h0000, 16'h0547, 16'h0142};
    spcch_dn_verdict_type dn_verdict_o;
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    initial forever #2 ref_clk_i = ~ref_clk_i;
    spcch_rc_model rc_u (.ref_clk_i(ref_clk_i), .tlp_i(tlp), .cfg_req_o(cfg_req_i));
    spcch_top dut_u (.*);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cfg(input logic w, input logic [11:0] o, input logic [3:0] be, input logic [31:0] d);
        @(posedge ref_clk_i);
        tlp <= '{1'b1, w, o, be, d};
        @(posedge ref_clk_i);
        tlp <= '0;
        for (int i = 0; i < 4 && cfg_ack_o !== 1'b1; i++) begin
            @(posedge ref_clk_i);
            #1;
        end
        chk("ack", 1, cfg_ack_o);
        r = cfg_rdata_o;
    endtask
    // Drives one pulse on every traffic input, then checks all verdicts a cycle later
    task automatic pulse(input spcch_pri_req_type p, input spcch_dn_req_type d, input logic [3:0] e,
        input logic [7:0] x);
        @(posedge ref_clk_i);
        pri_req_i <= p;
        dn_req_i <= d;
        {own_intx_i, err_fatal_i, err_nonfatal_i, parity_err_i} <= e;
        @(posedge ref_clk_i);
        pri_req_i <= '0;
        dn_req_i <= '0;
        {own_intx_i, err_fatal_i, err_nonfatal_i, parity_err_i} <= 4'h0;
        #1;
        chk("primary", x[7:6], {pri_claim_o, pri_ignore_o});
        chk("verdict", x[5:4], dn_verdict_o);
        chk("events", x[3:0], {own_intx_msg_o, err_fatal_msg_o, err_nonfatal_msg_o, parity_act_o});
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 1000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        logic [15:0] c;
        logic [7:0] x;
        repeat (20) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        cfg(1, 12'h000, 4'hf, 32'hffff_ffff);
        cfg(0, 12'h000, 4'hf, 32'h0000_0000);
        chk("ident", {`SPCCH_PART_RST, `SPCCH_MAKER_RST}, r);
        cfg(0, 12'h004, 4'hf, 32'h0000_0000);
        chk("cmd reset", 32'h0000_0000, r);
        cfg(1, 12'h004, 4'h3, 32'hffff_ffff);
        cfg(0, 12'h004, 4'hf, 32'h0000_0000);
        chk("cmd mask", 32'h0000_0547, r);
        cfg(1, 12'h004, 4'hc, 32'hffff_ffff);
        cfg(1, 12'h004, 4'h2, 32'h0000_0000);
        cfg(0, 12'h004, 4'hf, 32'h0000_0000);
        chk("cmd lane", 32'h0000_0047, r);
        cfg(0, 12'h008, 4'hf, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, r);
        @(posedge ref_clk_i);
        id_load_i <= '{1'b1, 2'b01, 32'h5555_1234};
        @(posedge ref_clk_i);
        id_load_i <= '{1'b1, 2'b10, 32'hbeef_0000};
        @(posedge ref_clk_i);
        id_load_i <= '0;
        cfg(0, 12'h000, 4'hf, 32'h0000_0000);
        chk("ident load", 32'hbeef_1234, r);
        $display("registers done");
        foreach (vals[k]) begin
            c = vals[k];
            cfg(1, 12'h004, 4'h3, {16'h0000, c});
            chk("cmd port", {16'h0000, c}, cmd_o);
            x = {c[0], !c[0], c[2] ? 2'd1 : 2'd2, !c[10], c[8], c[8], c[6]};
            pulse(3'b110, 5'b11000, 4'hf, x);
            x = {c[1], !c[1], c[2] ? 2'd1 : 2'd3, 4'h0};
            pulse(3'b101, 5'b10110, 4'h0, x);
            pulse(3'b100, 5'b10001, 4'h0, 8'h10);
        end
        $display("traffic done");
        final_report();
    end
endmodule
`default_nettype wire
